// ### core/cca_map.vh
`ifndef CCA_MAP_VH
`define CCA_MAP_VH

`define CCA_AW 4
`define CCA_DW 16

`define CCA_REG_OPA 4'h0
`define CCA_REG_OPB 4'h1
`define CCA_REG_CTRL 4'h2
`define CCA_REG_CMD 4'h3
`define CCA_REG_SUM 4'h4
`define CCA_REG_STAT 4'h5
`define CCA_REG_ACC 4'h6
`define CCA_REG_CNT8 4'h7
`define CCA_REG_CNT16 4'h8
`define CCA_REG_PROD 4'h9

`define CCA_CTRL_SUB 0
`define CCA_CTRL_INIT 1
`define CCA_CTRL_WLO 2
`define CCA_CTRL_WHI 3
`define CCA_CTRL_CRUN 4
`define CCA_CTRL_UP 5
`define CCA_CTRL_ARUN 6
`define CCA_CTRL_BITS 7
`define CCA_CTRL_RST 7'h20

`define CCA_CMD_CLR 0
`define CCA_CMD_LOAD 1
`define CCA_CMD_ACLR 2
`define CCA_CMD_CRST 3
`define CCA_CMD_MUL 4

`define CCA_ST_COUT 0
`define CCA_ST_GT 1
`define CCA_ST_EQ 2
`define CCA_ST_LT 3
`define CCA_ST_AND 4
`define CCA_ST_NAND 5
`define CCA_ST_OR 6
`define CCA_ST_NOR 7
`define CCA_ST_AND12 8
`define CCA_ST_BUSY 9

`define CCA_W16 2'h0
`define CCA_W8 2'h1
`define CCA_W4 2'h2
`define CCA_TOP16 15
`define CCA_TOP8 7
`define CCA_TOP4 3
`define CCA_MASK16 16'hffff
`define CCA_MASK8 16'h00ff
`define CCA_MASK4 16'h000f

`define CCA_MUL_W 8
`define CCA_MUL_LAST 3'h7

`endif

// ### core/cca_top.v
// Overview of operation
// RQ1 - Carry mux passes bypass operand when select low, incoming carry when high.
// RQ2 - Carry mux output feeds the next stage's carry or leaves as general output.
// RQ3 - Select comes from bit's lookup XOR; zero select always passes bypass operand.
// RQ4 - Constant one select always propagates carry, built inside the mux.
// RQ5 - Each slice holds a lower and an upper carry stage, two bits per slice.
// RQ6 - Stage offers chain output and a split general output, both usable together.
// RQ7 - Sum XOR combines half sum, equal to carry select, with incoming carry.
// RQ8 - Sum XOR carry comes from previous mux or a chain initialising signal.
// RQ9 - Sum XOR result drives combinational output or the registered output.
// RQ10 - Each sum bit is the lookup XOR XORed again with incoming carry.
// RQ11 - Partial-product gate takes two fixed inputs and drives only the bypass operand.
// RQ12 - In a multiplier bit the product gate duplicates one lookup AND term.
// RQ13 - No OR-chain element; sum-of-products OR is done in lookup logic.
// RQ14 - 16-input AND/NAND/NOR/OR use carry muxes; 12-input gates do not.
// RQ15 - 8- and 16-bit up-counters with clear and clock enable on the chain.
// RQ16 - Counters with clear, parallel load, enable and a direction control.
// RQ17 - 8- and 16-bit counters with reset and clock enable on the chain.
// RQ18 - 4/8/16-bit adders, adder/subtractors and accumulators use carry muxes and sum XORs.
// RQ19 - 8- and 16-bit magnitude comparators use carry muxes only, no sum XORs.
// RQ20 - Subtract inverts second operand and forces initial carry to one.
// RQ21 - Counters: clear/reset over load over count; all only with clock enable.
`timescale 1ns/100ps
`default_nettype none
`include "cca_map.vh"

module cca_top (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [`CCA_AW-1:0] addr,
	input wire [`CCA_DW-1:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [`CCA_DW-1:0] rdata_q
);

	localparam ST_IDLE = 1'b0;
	localparam ST_MUL = 1'b1;

	function carry_mux;
		input sel;
		input bypass_operand;
		input carry_in;
		begin
			carry_mux = sel ? carry_in : bypass_operand; // see RQ1
		end
	endfunction

	function sum_xor;
		input half_sum_in;
		input carry_in;
		begin
			sum_xor = half_sum_in ^ carry_in; // see RQ10
		end
	endfunction

	function cca_hit;
		input [`CCA_AW-1:0] a;
		input [`CCA_AW-1:0] idx;
		begin
			cca_hit = a == idx;
		end
	endfunction

	// The lower stage's chain output feeds the upper stage with no routing between
	function [2:0] cca_slice;
		input [1:0] a;
		input [1:0] b;
		input carry_in;
		reg lower_half;
		reg upper_half;
		reg lower_carry_stage;
		reg upper_carry_stage;
		reg lower_sum;
		reg upper_sum;
		begin
			lower_half = a[0] ^ b[0]; // see RQ3
			upper_half = a[1] ^ b[1]; // see RQ3
			lower_carry_stage = carry_mux(lower_half, a[0], carry_in); // see RQ1
			upper_carry_stage = carry_mux(upper_half, a[1], lower_carry_stage); // see RQ2
			lower_sum = sum_xor(lower_half, carry_in); // see RQ8
			upper_sum = sum_xor(upper_half, lower_carry_stage); // see RQ7
			cca_slice = {upper_carry_stage, upper_sum, lower_sum}; // see RQ5
		end
	endfunction

	function integer cca_top_bit;
		input [1:0] w;
		begin
			case (w)
				`CCA_W8: cca_top_bit = `CCA_TOP8;
				`CCA_W4: cca_top_bit = `CCA_TOP4;
				default: cca_top_bit = `CCA_TOP16;
			endcase
		end
	endfunction

	function [15:0] cca_mask;
		input [1:0] w;
		begin
			case (w)
				`CCA_W8: cca_mask = `CCA_MASK8;
				`CCA_W4: cca_mask = `CCA_MASK4;
				default: cca_mask = `CCA_MASK16;
			endcase
		end
	endfunction

	// Ripple chain of slices; every width ends on an upper stage
	function [16:0] cca_add;
		input [15:0] a;
		input [15:0] b;
		input cin;
		input [1:0] w;
		reg c;
		reg co;
		reg [2:0] r;
		reg [15:0] s;
		integer i;
		begin
			c = cin; // see RQ8
			co = 1'b0;
			s = 16'h0000;
			for (i = 0; i < 16; i = i + 2) begin
				r = cca_slice(a[i +: 2], b[i +: 2], c); // see RQ5
				s[i +: 2] = r[1:0]; // see RQ10
				c = r[2];
				if (i + 1 == cca_top_bit(w)) begin
					co = c; // see RQ6
				end
			end
			cca_add = {co, s & cca_mask(w)}; // see RQ18
		end
	endfunction

	// Magnitude compare on muxes alone; bits above the width count as equal
	function [1:0] cca_cmp;
		input [15:0] a;
		input [15:0] b;
		input [1:0] w;
		reg gt;
		reg eq;
		reg sel;
		reg [15:0] m;
		integer i;
		begin
			gt = 1'b0;
			eq = 1'b1;
			m = cca_mask(w);
			for (i = 0; i < 16; i = i + 1) begin
				sel = ~(a[i] ^ b[i]) | ~m[i];
				gt = carry_mux(sel, a[i], gt); // see RQ19
				eq = carry_mux(sel, 1'b0, eq); // see RQ19
			end
			cca_cmp = {eq, gt};
		end
	endfunction

	function cca_wide_and;
		input [15:0] x;
		reg c;
		integer i;
		begin
			c = 1'b1; // see RQ4
			for (i = 0; i < 16; i = i + 1) begin
				c = carry_mux(x[i], 1'b0, c); // see RQ14
			end
			cca_wide_and = c;
		end
	endfunction

	// One multiplier row; the product gate feeds only the bypass operand
	function [15:0] cca_mac_row;
		input [15:0] p;
		input [15:0] a;
		input bj;
		reg c;
		reg pg;
		reg hs;
		reg [15:0] s;
		integer i;
		begin
			c = 1'b0;
			s = 16'h0000;
			for (i = 0; i < 16; i = i + 1) begin
				pg = a[i] & bj; // see RQ11
				hs = (a[i] & bj) ^ p[i]; // see RQ12
				s[i] = sum_xor(hs, c);
				c = carry_mux(hs, pg, c); // see RQ11
			end
			cca_mac_row = s;
		end
	endfunction

	reg [15:0] opa_q;
	reg [15:0] opb_q;
	reg [`CCA_CTRL_BITS-1:0] ctrl_q;
	reg [15:0] sum_q;
	reg cout_q;
	reg [1:0] cmp_q;
	reg [3:0] gate_q;
	reg and12_q;
	reg [15:0] acc_q;
	reg [7:0] cnt8_q;
	reg [15:0] cnt16_q;
	reg [15:0] prod_q;
	reg [15:0] mcand_q;
	reg [7:0] mplier_q;
	reg [2:0] step_q;
	reg state_q;

	wire wr_opa = wr_stb && cca_hit(addr, `CCA_REG_OPA);
	wire wr_opb = wr_stb && cca_hit(addr, `CCA_REG_OPB);
	wire wr_ctrl = wr_stb && cca_hit(addr, `CCA_REG_CTRL);
	wire wr_cmd = wr_stb && cca_hit(addr, `CCA_REG_CMD);
	wire cmd_clr = wr_cmd && wdata[`CCA_CMD_CLR];
	wire cmd_load = wr_cmd && wdata[`CCA_CMD_LOAD];
	wire cmd_aclr = wr_cmd && wdata[`CCA_CMD_ACLR];
	wire cmd_crst = wr_cmd && wdata[`CCA_CMD_CRST];
	wire cmd_mul = wr_cmd && wdata[`CCA_CMD_MUL];

	wire sub = ctrl_q[`CCA_CTRL_SUB];
	wire [1:0] wsel = ctrl_q[`CCA_CTRL_WHI:`CCA_CTRL_WLO];
	wire up = ctrl_q[`CCA_CTRL_UP];
	wire [15:0] opb_eff = sub ? ~opb_q : opb_q; // see RQ20
	wire cin_eff = sub | ctrl_q[`CCA_CTRL_INIT]; // see RQ20

	wire [16:0] add_res = cca_add(opa_q, opb_eff, cin_eff, wsel);
	wire [16:0] acc_res = cca_add(acc_q, opb_eff, cin_eff, wsel);
	// Down counting adds all ones; up counting is a forced carry into a zero operand
	wire [15:0] step_b = up ? 16'h0000 : 16'hffff;
	wire [16:0] c8_res = cca_add({8'h00, cnt8_q}, step_b, up, `CCA_W8); // see RQ15
	wire [16:0] c16_res = cca_add(cnt16_q, step_b, up, `CCA_W16); // see RQ15
	wire [1:0] cmp_res = cca_cmp(opa_q, opb_q, wsel == `CCA_W8 ? `CCA_W8 : `CCA_W16);
	wire and16 = cca_wide_and(opa_q);
	wire nor16 = cca_wide_and(~opa_q);
	wire nand16 = ~and16;
	wire or16 = ~nor16;
	// Less-than needs no chain of its own: it is neither greater nor equal
	wire cmp_lt = ~cmp_q[1] & ~cmp_q[0];

	always @(posedge clock) begin
		if (rst) begin
			opa_q <= 16'h0000;
			opb_q <= 16'h0000;
			ctrl_q <= `CCA_CTRL_RST;
		end else if (ce && wr_stb) begin
			if (wr_opa) begin
				opa_q <= wdata;
			end
			if (wr_opb) begin
				opb_q <= wdata;
			end
			if (wr_ctrl) begin
				ctrl_q <= wdata[`CCA_CTRL_BITS-1:0];
			end
		end
	end

	// Results are registered so every result read is a flop output, except less-than, which is decoded from cmp_q
	always @(posedge clock) begin
		if (rst) begin
			sum_q <= 16'h0000;
			cout_q <= 1'b0;
			cmp_q <= 2'h0;
			gate_q <= 4'h0;
			and12_q <= 1'b0;
		end else if (ce) begin
			sum_q <= add_res[15:0]; // see RQ9
			cout_q <= add_res[16];
			cmp_q <= cmp_res;
			gate_q <= {nor16, or16, nand16, and16}; // see RQ14
			// Twelve inputs fit lookups, so no chain is spent here; OR also stays in logic
			and12_q <= &opa_q[11:0]; // see RQ13
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			acc_q <= 16'h0000;
		end else if (ce) begin
			if (cmd_aclr) begin
				acc_q <= 16'h0000;
			end else if (ctrl_q[`CCA_CTRL_ARUN]) begin
				acc_q <= acc_res[15:0]; // see RQ18
			end
		end
	end

	// Reset and clear share one priority level, above load and count
	// Both counters wrap silently; no terminal count leaves the block
	always @(posedge clock) begin
		if (rst) begin
			cnt8_q <= 8'h00;
			cnt16_q <= 16'h0000;
		end else if (ce) begin // see RQ21
			if (cmd_crst || cmd_clr) begin // see RQ17
				cnt8_q <= 8'h00;
				cnt16_q <= 16'h0000;
			end else if (cmd_load) begin // see RQ16
				cnt8_q <= opa_q[7:0];
				cnt16_q <= opa_q;
			end else if (ctrl_q[`CCA_CTRL_CRUN]) begin
				cnt8_q <= c8_res[7:0]; // see RQ16
				cnt16_q <= c16_res[15:0];
			end
		end
	end

	// Shift-add multiply of the low operand bytes, one row per cycle
	always @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			prod_q <= 16'h0000;
			mcand_q <= 16'h0000;
			mplier_q <= 8'h00;
			step_q <= 3'h0;
		end else if (ce) begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_mul) begin
						state_q <= ST_MUL;
						prod_q <= 16'h0000;
						mcand_q <= {8'h00, opa_q[7:0]};
						mplier_q <= opb_q[7:0];
						step_q <= 3'h0;
					end
				end
				ST_MUL: begin
					prod_q <= cca_mac_row(prod_q, mcand_q, mplier_q[0]); // see RQ12
					mcand_q <= {mcand_q[14:0], 1'b0};
					mplier_q <= {1'b0, mplier_q[7:1]};
					step_q <= step_q + 3'h1;
					if (step_q == `CCA_MUL_LAST) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	wire [15:0] stat_word = {6'h00, state_q, and12_q, gate_q, cmp_lt, cmp_q, cout_q};

	// Held, not cleared, while enable is low so a frozen read stays visible
	always @(posedge clock) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (ce) begin
			if (rd_stb) begin
				case (addr)
					`CCA_REG_OPA: rdata_q <= opa_q;
					`CCA_REG_OPB: rdata_q <= opb_q;
					`CCA_REG_CTRL: rdata_q <= {9'h000, ctrl_q};
					`CCA_REG_SUM: rdata_q <= sum_q;
					`CCA_REG_STAT: rdata_q <= stat_word;
					`CCA_REG_ACC: rdata_q <= acc_q;
					`CCA_REG_CNT8: rdata_q <= {8'h00, cnt8_q};
					`CCA_REG_CNT16: rdata_q <= cnt16_q;
					`CCA_REG_PROD: rdata_q <= prod_q;
					default: rdata_q <= 16'h0000;
				endcase
			end else begin
				rdata_q <= 16'h0000;
			end
		end
	end

endmodule

`default_nettype wire

// ### dv/cca_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cca_top_assertions (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	input wire [15:0] rdata_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_idle; ce && !rd_stb |=> rdata_q == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data not cleared");
	property p_hold; !ce |=> $stable(rdata_q); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without enable");
	property p_unmap; ce && rd_stb && addr > 4'h9 |=> rdata_q == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_opa;
		ce && wr_stb && addr == 4'h0 ##1 ce && rd_stb && addr == 4'h0 |=> rdata_q == $past(wdata, 2);
	endproperty
	a_opa: assert property (p_opa) else $error("operand readback wrong");
	property p_ctrl;
		ce && wr_stb && addr == 4'h2 ##1 ce && rd_stb && addr == 4'h2 |=> rdata_q == ($past(wdata, 2) & 16'h007f);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
	property p_narrow; ce && rd_stb && addr == 4'h7 |=> rdata_q[15:8] == 8'h00; endproperty
	a_narrow: assert property (p_narrow) else $error("narrow counter upper bits set");
	property p_cmp; ce && rd_stb && addr == 4'h5 |=> $onehot(rdata_q[3:1]); endproperty
	a_cmp: assert property (p_cmp) else $error("compare flags not one-hot");
	property p_gate;
		ce && rd_stb && addr == 4'h5 |=> rdata_q[5] != rdata_q[4] && rdata_q[7] != rdata_q[6] && (!rdata_q[4] || rdata_q[8]);
	endproperty
	a_gate: assert property (p_gate) else $error("wide gate flags inconsistent");
endmodule
bind cca_top cca_top_assertions cca_top_assertions_i (.clock(clock), .rst(rst), .ce(ce), .addr(addr),
	.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q));
`default_nettype wire

// ### dv/test_carry_chain_arith.sv
`timescale 1ns/100ps
`default_nettype none
`include "cca_map.vh"
module test_carry_chain_arith;
	logic clock = 0, rst = 1, ce = 1, wr_stb = 0, rd_stb = 0;
	logic [3:0] addr = 0;
	logic [15:0] wdata = 0, d, a, b, c;
	logic [16:0] s;
	logic [31:0] seed = 32'he8e624ee;
	int fails = 0, comparisons = 0, i;
	wire [15:0] rdata_q;
	logic [47:0] cor [5] = '{48'hffff00010020, 48'h000000000021, 48'h123412340022, 48'h000f00010028, 48'h000000010025};
	cca_top cca_top_i (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata_q(rdata_q));
	initial forever #25 clock = ~clock;
	function logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function logic [15:0] mk(input logic [15:0] c);
		return c[3:2] == 2'h0 ? 16'hffff : c[3:2] == 2'h1 ? 16'h00ff : 16'h000f;
	endfunction
	function logic [16:0] es(input logic [15:0] a, b, c);
		logic [16:0] r;
		r = (a & mk(c)) + ((c[0] ? ~b : b) & mk(c)) + (c[0] | c[1]);
		return {c[3:2] == 2'h0 ? r[16] : c[3:2] == 2'h1 ? r[8] : r[4], r[15:0] & mk(c)};
	endfunction
	function logic [15:0] est(input logic [15:0] a, b, c, input logic co);
		logic [15:0] m;
		m = c[3:2] == 2'h1 ? 16'h00ff : 16'hffff;
		return {7'h0, &a[11:0], ~|a, |a, ~&a, &a, (a & m) < (b & m), (a & m) == (b & m), (a & m) > (b & m), co};
	endfunction
	task wr(input logic [3:0] a, input logic [15:0] v);
		addr <= a;
		wdata <= v;
		wr_stb <= 1;
		// Strobe stays up until a later rd or an explicit clear lowers it, so it is never set twice at once
		@(posedge clock);
	endtask
	task rd(input logic [3:0] a, output logic [15:0] v);
		addr <= a;
		wr_stb <= 0;
		rd_stb <= 1;
		@(posedge clock);
		rd_stb <= 0;
		#1 v = rdata_q;
		@(posedge clock);
	endtask
	task chk(input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task rc(input logic [3:0] a, input logic [15:0] e);
		rd(a, d);
		chk(d, e);
	endtask
	// Enable is dropped for m cycles inside the window; the counters still advance n times, so n must be at least 1
	task run(input logic [15:0] c, input int n, m);
		wr(2, c);
		wr_stb <= 0;
		ce <= 0;
		repeat (m) @(posedge clock);
		ce <= 1;
		repeat (n - 1) @(posedge clock);
		wr(2, 16'h0020);
	endtask
	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#5000000;
		fails++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		rc(2, `CCA_CTRL_RST);
		rc(4, 0);
		rc(8, 0);
		rc(4'hf, 0);
		for (i = 0; i < 45; i++) begin
			{a, b, c} = i < 5 ? cor[i] : {xs(), xs(), 16'h0020 | (xs() % 16'h0003) << 2 | xs() & 16'h0003};
			wr(0, a);
			wr(1, b);
			wr(2, c);
			wr_stb <= 0;
			@(posedge clock);
			s = es(a, b, c);
			rc(4, s[15:0]);
			rc(5, est(a, b, c, s[16]));
		end
		wr(4, 16'h5a5a);
		rc(4, s[15:0]);
		ce <= 0;
		wr(0, 16'h1111);
		ce <= 1;
		rc(0, a);
		wr(0, 16'hbeef);
		rc(0, 16'hbeef);
		wr(2, 16'hffa5);
		rc(2, 16'h0025);
		wr(3, 16'h000d);
		b = xs();
		wr(1, b);
		run(16'h0070, 37, 3);
		rc(8, 16'd37);
		rc(7, 16'd37);
		rc(6, 16'd37 * b);
		wr(0, 16'hfffe);
		wr(3, 16'h0002);
		rc(8, 16'hfffe);
		rc(7, 16'h00fe);
		run(16'h0030, 5, 1);
		rc(8, 16'h0003);
		wr(3, 16'h0004);
		run(16'h0055, 4, 2);
		rc(8, 16'hffff);
		rc(7, 16'h00ff);
		rc(6, (16'h0000 - 16'd4 * b) & 16'h00ff);
		wr(3, 16'h0003);
		rc(8, 16'h0000);
		a = xs();
		b = xs();
		wr(0, a);
		wr(1, b);
		wr(3, 16'h0010);
		rd(5, d);
		chk({15'h0, d[9]}, 16'h0001);
		for (i = 0; i < 20 && d[9] !== 1'b0; i++)
			rd(5, d);
		if (i == 20)
			fails++;
		rc(9, {8'h00, a[7:0]} * {8'h00, b[7:0]});
		give_verdict;
	end
endmodule
`default_nettype wire
